// ### verilog/sct_regs.svh
/*
 Constants for the sink calendar and status table block: sizes, codes, reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

`define SCT_CAL_DEPTH    512
`define SCT_CHAN_COUNT   256
`define SCT_BANK_WIDTH   16
`define SCT_FRAME_WORD   2'h3
`define SCT_STATUS_RST   2'h0
`define SCT_CHAN_RST     8'h00
`define SCT_LEN_RST      9'h000
`define SCT_PER_RST      8'h00

`endif

// ### verilog/sct_pkg.sv
/*
 Types for the sink calendar and status table block.
 Assumes sct_regs.svh is on the include path.
*/
package sct_pkg;
   `include "sct_regs.svh"

   typedef enum logic [1:0] {SCT_IDLE, SCT_FRAME, SCT_SLOT, SCT_DIP} sct_state_e;

   // Calendar port group
   typedef struct packed {
      logic       clock;
      logic       write_enable_low;
      logic [8:0] entry_index;
      logic [7:0] write_channel;
   } sct_cal_in_s;

   // Status write port group
   typedef struct packed {
      logic        clock;
      logic [31:0] word;
      logic [3:0]  bank;
      logic        strobe_low;
      logic [15:0] mask;
      logic        corrupt_request;
   } sct_stat_in_s;

   // Calendar run settings
   typedef struct packed {
      logic       enable;
      logic [8:0] length;
      logic [7:0] period;
   } sct_cfg_s;

   // State register of the top module, apart from its two memories
   typedef struct packed {
      logic       cal_prev;
      logic       stat_prev;
      logic [7:0] read_channel;
      sct_state_e state;
      logic [8:0] cal_idx;
      logic [7:0] rep;
      logic [8:0] len;
      logic [7:0] per;
      logic [1:0] dip_acc;
      logic       corrupt_pend;
      logic [1:0] bus;
   } sct_top_s;
endpackage : sct_pkg

// ### verilog/sct_sync.sv
/*
 Two flip-flop synchroniser for a bundle of pin inputs.
 Assumes each bit is a level from outside the clk domain.
*/
`timescale 1ns/1ps
module sct_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin,
   output      logic [W-1:0] sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sct_sync_s;

   sct_sync_s st;
   sct_sync_s next_st;

   always_comb begin
      next_st      = st;
      next_st.meta = pin;
      next_st.held = st.meta;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync = st.held;
endmodule : sct_sync

// ### verilog/sct_status_table.sv
/*
 Calendar memory, 256-channel status table and status sequencer with DIP-2.
 Assumes calendar and status ports come from outside clk; both are sampled
 through two flip-flops, and their own clocks are sampled as levels whose
 rising edges are detected on clk. Those clocks must be well below clk/2.
*/
`timescale 1ns/1ps
`include "sct_regs.svh"

module sct_status_table
   import sct_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        calendar_clock,
   input  wire logic        calendar_write_enable_low,
   input  wire logic [8:0]  calendar_entry_index,
   input  wire logic [7:0]  calendar_write_channel,
   output      logic [7:0]  calendar_read_channel,
   input  wire logic        status_write_clock,
   input  wire logic [31:0] status_input_word,
   input  wire logic [3:0]  status_bank_select,
   input  wire logic        status_write_strobe_low,
   input  wire logic [15:0] status_channel_mask,
   input  wire logic        parity_corrupt_request,
   input  wire logic        receive_side_enable,
   input  wire logic [8:0]  calendar_length_setting,
   input  wire logic [7:0]  calendar_period_setting,
   output      logic [1:0]  outgoing_status_bus
);
   import sct_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   sct_cal_in_s  ci;
   sct_stat_in_s si;
   sct_cfg_s     cfg;

   sct_sync #(.W($bits(sct_cal_in_s))) u_cal_sync (
      .clk  (clk),
      .rstn (rstn),
      .pin  ({calendar_clock, calendar_write_enable_low,
              calendar_entry_index, calendar_write_channel}),
      .sync (ci)
   );

   sct_sync #(.W($bits(sct_stat_in_s))) u_stat_sync (
      .clk  (clk),
      .rstn (rstn),
      .pin  ({status_write_clock, status_input_word, status_bank_select,
              status_write_strobe_low, status_channel_mask,
              parity_corrupt_request}),
      .sync (si)
   );

   sct_sync #(.W($bits(sct_cfg_s))) u_cfg_sync (
      .clk  (clk),
      .rstn (rstn),
      .pin  ({receive_side_enable, calendar_length_setting,
              calendar_period_setting}),
      .sync (cfg)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] chan_of(input logic [3:0] bank,
                                          input logic [3:0] lane);
      chan_of = {bank, lane};
   endfunction : chan_of

   // ----------------------------------------------------------------
   // State and memories
   // ----------------------------------------------------------------
   sct_top_s   st;
   sct_top_s   next_st;
   logic [7:0] cal_mem  [`SCT_CAL_DEPTH];
   logic [1:0] stat_tbl [`SCT_CHAN_COUNT];

   logic       cal_edge;
   logic       stat_edge;
   logic       cal_write;
   logic       stat_write;
   logic [1:0] slot_status;
   logic [1:0] bank_lane0;
   logic       last_entry;
   logic       last_pass;

   always_comb begin
      cal_edge    = ci.clock & ~st.cal_prev;
      stat_edge   = si.clock & ~st.stat_prev;
      cal_write   = cal_edge & ~ci.write_enable_low;
      stat_write  = stat_edge & ~si.strobe_low;
      slot_status = stat_tbl[cal_mem[st.cal_idx]];
      bank_lane0  = stat_tbl[chan_of(si.bank, 4'h0)];
      last_entry  = (st.cal_idx == st.len);
      last_pass   = (st.rep == st.per);
   end

   // ----------------------------------------------------------------
   // Calendar memory
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cal_write) begin
         cal_mem[ci.entry_index] <= ci.write_channel;
      end
   end

   // ----------------------------------------------------------------
   // Status table, sixteen masked lanes per write
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      for (int x = 0; x < `SCT_BANK_WIDTH; x++) begin
         if (stat_write && si.mask[x]) begin
            stat_tbl[chan_of(si.bank, 4'(x))] <= si.word[2*x +: 2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st           = st;
      next_st.cal_prev  = ci.clock;
      next_st.stat_prev = si.clock;
      if (cal_edge && ci.write_enable_low) begin
         next_st.read_channel = cal_mem[ci.entry_index];
      end
      unique case (st.state)
         SCT_IDLE: begin
            next_st.bus     = `SCT_FRAME_WORD;
            next_st.len     = cfg.length;
            next_st.per     = cfg.period;
            next_st.dip_acc = 2'h0;
            if (cfg.enable) begin
               next_st.state = SCT_FRAME;
            end
         end
         SCT_FRAME: begin
            next_st.bus     = `SCT_FRAME_WORD;
            next_st.cal_idx = 9'h000;
            next_st.rep     = 8'h00;
            next_st.state   = SCT_SLOT;
         end
         SCT_SLOT: begin
            next_st.bus     = slot_status;
            next_st.dip_acc = st.dip_acc ^ slot_status;
            if (last_entry) begin
               next_st.cal_idx = 9'h000;
               if (last_pass) begin
                  next_st.state = SCT_DIP;
               end else begin
                  next_st.rep = st.rep + 8'h01;
               end
            end else begin
               next_st.cal_idx = st.cal_idx + 9'h001;
            end
         end
         SCT_DIP: begin
            next_st.bus     = ~st.dip_acc ^ {2{st.corrupt_pend}};
            next_st.dip_acc = 2'h0;
            next_st.state   = cfg.enable ? SCT_FRAME : SCT_IDLE;
         end
      endcase
      // Request arriving as the DIP word goes out waits for the next one
      next_st.corrupt_pend = (st.corrupt_pend & (st.state != SCT_DIP))
                           | (stat_edge & si.corrupt_request);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st              <= '0;
         st.state        <= SCT_IDLE;
         st.read_channel <= `SCT_CHAN_RST;
         st.len          <= `SCT_LEN_RST;
         st.per          <= `SCT_PER_RST;
         st.bus          <= `SCT_FRAME_WORD;
      end else begin
         st <= next_st;
      end
   end

   assign calendar_read_channel = st.read_channel;
   assign outgoing_status_bus   = st.bus;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_last_slot;
      st.state == SCT_SLOT && last_entry && last_pass;
   endsequence

   sequence s_dip_out;
      st.state == SCT_DIP ##1 st.state != SCT_DIP;
   endsequence

   property p_cal_write;
      cal_write |=> cal_mem[$past(ci.entry_index)] == $past(ci.write_channel);
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("calendar write lost");

   property p_cal_read;
      (cal_edge && ci.write_enable_low) |=>
         calendar_read_channel == cal_mem[$past(ci.entry_index)];
   endproperty
   a_cal_read: assert property (p_cal_read) else $error("calendar read wrong");

   property p_slot_order;
      (st.state == SCT_SLOT && !cal_write && !stat_write) |=>
         outgoing_status_bus == $past(slot_status);
   endproperty
   a_slot_order: assert property (p_slot_order) else $error("slot status wrong");

   property p_idx_wrap;
      (st.state == SCT_SLOT && last_entry && !last_pass) |=>
         st.cal_idx == 9'h000 && st.rep == $past(st.rep) + 8'h01 && st.state == SCT_SLOT;
   endproperty
   a_idx_wrap: assert property (p_idx_wrap) else $error("pass wrap wrong");

   property p_dip_after;
      s_last_slot |=> s_dip_out;
   endproperty
   a_dip_after: assert property (p_dip_after) else $error("DIP-2 not inserted");

   property p_corrupt;
      (st.state == SCT_DIP && st.corrupt_pend) |=>
         outgoing_status_bus == $past(st.dip_acc);
   endproperty
   a_corrupt: assert property (p_corrupt) else $error("parity not inverted");

   property p_mask_write;
      (stat_write && si.mask[0]) |=>
         stat_tbl[$past(chan_of(si.bank, 4'h0))] == $past(si.word[1:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("masked write lost");

   property p_mask_keep;
      (stat_edge && (si.strobe_low || !si.mask[0])) |=>
         stat_tbl[$past(chan_of(si.bank, 4'h0))] == $past(bank_lane0);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("table changed");

   property p_pend_set;
      (stat_edge && si.corrupt_request) |=> st.corrupt_pend;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("corrupt request lost");

   property p_lane_top;
      (stat_write && si.mask[15]) |=>
         stat_tbl[$past(chan_of(si.bank, 4'hF))] == $past(si.word[31:30]);
   endproperty
   a_lane_top: assert property (p_lane_top) else $error("top lane lost");

   property p_idle_word;
      (st.state == SCT_IDLE) |=> outgoing_status_bus == `SCT_FRAME_WORD;
   endproperty
   a_idle_word: assert property (p_idle_word) else $error("idle word wrong");

   property p_frame_go;
      (st.state == SCT_FRAME) |=>
         st.state == SCT_SLOT && st.cal_idx == 9'h000 && st.rep == 8'h00;
   endproperty
   a_frame_go: assert property (p_frame_go) else $error("frame start wrong");

   property p_idx_step;
      (st.state == SCT_SLOT && !last_entry) |=>
         st.cal_idx == $past(st.cal_idx) + 9'h001 && st.state == SCT_SLOT;
   endproperty
   a_idx_step: assert property (p_idx_step) else $error("entry step wrong");

   property p_dip_plain;
      (st.state == SCT_DIP && !st.corrupt_pend) |=>
         outgoing_status_bus == ~$past(st.dip_acc);
   endproperty
   a_dip_plain: assert property (p_dip_plain) else $error("parity wrong");

   property p_pend_clear;
      (st.state == SCT_DIP && !(stat_edge && si.corrupt_request)) |=> !st.corrupt_pend;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("corrupt request kept");

   property p_set_hold;
      (st.state != SCT_IDLE) |=> st.len == $past(st.len) && st.per == $past(st.per);
   endproperty
   a_set_hold: assert property (p_set_hold) else $error("settings moved");

   property p_read_hold;
      !(cal_edge && ci.write_enable_low) |=> $stable(calendar_read_channel);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read channel moved");
endmodule : sct_status_table

// ### dv/sct_user_model.sv
/*
 Partner model: user logic that fills the calendar and the status table.
 Assumes the block samples both pin clocks as levels on clk.
*/
`timescale 1ns/1ps
module sct_user_model (
   input  wire logic        clk,
   output      logic        calendar_clock,
   output      logic        calendar_write_enable_low,
   output      logic [8:0]  calendar_entry_index,
   output      logic [7:0]  calendar_write_channel,
   input  wire logic [7:0]  calendar_read_channel,
   output      logic        status_write_clock,
   output      logic [31:0] status_input_word,
   output      logic [3:0]  status_bank_select,
   output      logic        status_write_strobe_low,
   output      logic [15:0] status_channel_mask,
   output      logic        parity_corrupt_request
);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   initial begin
      calendar_clock = 1'b0;
      calendar_write_enable_low = 1'b1;
      calendar_entry_index = 9'h000;
      calendar_write_channel = 8'h00;
      status_write_clock = 1'b0;
      status_input_word = 32'h0;
      status_bank_select = 4'h0;
      status_write_strobe_low = 1'b1;
      status_channel_mask = 16'h0;
      parity_corrupt_request = 1'b0;
   end

   // Pins settle, clock rises, holds, falls; data lines then show garbage
   task automatic cal_op(input logic w, input logic [8:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      tick(1);
      calendar_write_enable_low = w;
      calendar_entry_index = a;
      calendar_write_channel = d;
      tick(4);
      calendar_clock = 1'b1;
      tick(4);
      calendar_clock = 1'b0;
      tick(4);
      q = calendar_read_channel;
      calendar_write_enable_low = 1'b1;
      calendar_entry_index = ~a;
      calendar_write_channel = ~d;
   endtask : cal_op

   task automatic st_op(input logic [3:0] b, input logic [15:0] m, input logic [31:0] wd,
                        input logic s, input logic e);
      tick(1);
      status_bank_select = b;
      status_channel_mask = m;
      status_input_word = wd;
      status_write_strobe_low = s;
      parity_corrupt_request = e;
      tick(4);
      status_write_clock = 1'b1;
      tick(4);
      status_write_clock = 1'b0;
      tick(4);
      status_write_strobe_low = 1'b1;
      parity_corrupt_request = 1'b0;
      status_bank_select = ~b;
      status_channel_mask = ~m;
      status_input_word = ~wd;
   endtask : st_op
endmodule : sct_user_model

// ### dv/testbench.sv
/*
 Self-checking bench for sct_status_table with the user-logic partner.
 Assumes framing word 2'b11 and DIP-2 as the inverted XOR of a frame's slot words.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench;
   import sct_pkg::*;
   logic        clk, rstn, receive_side_enable;
   logic        calendar_clock, calendar_write_enable_low, status_write_clock;
   logic        status_write_strobe_low, parity_corrupt_request;
   logic [8:0]  calendar_entry_index, calendar_length_setting;
   logic [7:0]  calendar_write_channel, calendar_read_channel, calendar_period_setting;
   logic [31:0] status_input_word;
   logic [3:0]  status_bank_select;
   logic [15:0] status_channel_mask;
   logic [1:0]  outgoing_status_bus;
   logic [7:0]  q;
   logic [1:0]  sx [4] = '{2'h1, 2'h2, 2'h1, 2'h1};
   int          miscompares = 0;
   int          checks_done = 0;
   int          cyc = 0;

   sct_status_table i_dut (.clk, .rstn, .calendar_clock, .calendar_write_enable_low,
      .calendar_entry_index, .calendar_write_channel, .calendar_read_channel,
      .status_write_clock, .status_input_word, .status_bank_select,
      .status_write_strobe_low, .status_channel_mask, .parity_corrupt_request,
      .receive_side_enable, .calendar_length_setting, .calendar_period_setting,
      .outgoing_status_bus);
   sct_user_model i_user (.clk, .calendar_clock, .calendar_write_enable_low,
      .calendar_entry_index, .calendar_write_channel, .calendar_read_channel,
      .status_write_clock, .status_input_word, .status_bank_select,
      .status_write_strobe_low, .status_channel_mask, .parity_corrupt_request);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         results();
      end
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic wait_bus(input logic [1:0] v, input logic eq);
      int n;
      for (n = 0; n < 60 && ((outgoing_status_bus === v) != eq); n++)
         i_user.tick(1);
      `CHK("wait", eq, outgoing_status_bus === v)
   endtask : wait_bus

   // Frame: four entries, three passes, then parity
   task automatic check_frame(input logic [1:0] d);
      int i;
      wait_bus(2'h3, 1'b1);
      wait_bus(2'h3, 1'b0);
      for (i = 0; i < 12; i++) begin
         `CHK("slot", sx[i % 4], outgoing_status_bus)
         i_user.tick(1);
      end
      `CHK("dip", d, outgoing_status_bus)
   endtask : check_frame

   task automatic t_calendar;
      logic [8:0] a [5] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h1FF};
      logic [7:0] d [5] = '{8'h05, 8'h1F, 8'h05, 8'hFF, 8'hA6};
      int i;
      for (i = 0; i < 5; i++)
         i_user.cal_op(1'b0, a[i], d[i], q);
      for (i = 0; i < 5; i++) begin
         i_user.cal_op(1'b1, a[i], 8'h00, q);
         `CHK("cal", d[i], q)
      end
   endtask : t_calendar

   task automatic t_status;
      i_user.st_op(4'h0, 16'hFFFF, 32'h0000_0400, 1'b0, 1'b0);
      i_user.st_op(4'h1, 16'hFFFF, 32'h8000_0000, 1'b0, 1'b0);
      i_user.st_op(4'hF, 16'hFFFF, 32'h4000_0000, 1'b0, 1'b0);
      i_user.st_op(4'h0, 16'hFFFF, 32'hFFFF_FFFF, 1'b1, 1'b0);
      i_user.st_op(4'h0, 16'h0000, 32'hFFFF_FFFF, 1'b0, 1'b0);
      i_user.st_op(4'h0, 16'hFFDF, 32'hFFFF_FFFF, 1'b0, 1'b0);
   endtask : t_status

   task automatic t_run;
      calendar_length_setting = 9'h003;
      calendar_period_setting = 8'h02;
      receive_side_enable = 1'b1;
      check_frame(2'h0);
      check_frame(2'h0);
   endtask : t_run

   task automatic t_corrupt;
      fork
         i_user.st_op(4'h0, 16'h0000, 32'h0, 1'b1, 1'b1);
         check_frame(2'h3);
      join
      check_frame(2'h0);
   endtask : t_corrupt

   initial begin
      rstn = 1'b0;
      receive_side_enable = 1'b0;
      calendar_length_setting = 9'h000;
      calendar_period_setting = 8'h00;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      i_user.tick(3);
      t_calendar();
      t_status();
      t_run();
      t_corrupt();
      results();
   end
endmodule : testbench
